/* cmpctl_top.sv */
// Comparator input control: input selection, output synchroniser, edge
// interrupt flag, capture routing and pin buffer disables, with a classic
// Wishbone slave for its registers.
// Assumes an analog core outside that takes the select outputs, and a CPU
// that pulses vector_ack_i when it takes the comparator vector.
`timescale 1ns/1ns
module cmpctl_top
(
  // Clock, reset and enable
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        ce_i,
  // Wishbone slave
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [7:0]  adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic      [31:0] dat_o,
  output logic             ack_o,
  output logic             err_o,
  // CPU side
  input  wire logic        global_irq_en_i,
  input  wire logic        vector_ack_i,
  output logic             comp_irq_req_o,
  output logic             irq_o,
  // Analog core
  input  wire logic        cmp_raw_i,
  output logic             comp_power_down_o,
  output logic             pos_use_bandgap_o,
  output logic             neg_use_channel_o,
  output logic      [2:0]  neg_channel_o,
  // Timer capture front end
  output logic             capture_in_o,
  // Pin buffers
  input  wire logic        neg_pin_raw_i,
  input  wire logic        pos_pin_raw_i,
  output logic             neg_pin_state_o,
  output logic             pos_pin_state_o,
  output logic             neg_buffer_off_o,
  output logic             pos_buffer_off_o
);

  // -------------------------------------------------------------------
  // Registers
  // -------------------------------------------------------------------
  logic [7:0] ctrl_r;      // Control bits; bits 5 and 4 unused here
  logic       irq_flag_r;
  logic [7:0] conv_b_r;
  logic [1:0] in_dis_r;
  logic       conv_en_r;
  logic [2:0] chan_r;
  logic       ack_r;
  logic [31:0] rdata_r;
  logic       err_r;
  logic [cmpctl_pkg::CMPCTL_NUM_EVENTS-1:0] ev_status;
  logic [cmpctl_pkg::CMPCTL_NUM_EVENTS-1:0] ev_enable;
  logic [cmpctl_pkg::CMPCTL_NUM_EVENTS-1:0] ev_set;
  logic [cmpctl_pkg::CMPCTL_NUM_EVENTS-1:0] ev_clr;
  logic       cap_prev_r;

  cmpctl_edge_if edge_if ();

  // -------------------------------------------------------------------
  // Bus decode
  // -------------------------------------------------------------------
  logic       req;
  logic       wr;
  logic       lane0;
  logic [7:0] wb0;
  logic       hit;

  assign req   = cyc_i & stb_i & ~ack_r;
  assign wr    = req & we_i & ce_i;
  assign lane0 = sel_i[0];
  assign wb0   = dat_i[7:0];

  // Address recognised
  always_comb
  begin
    case (adr_i)
      cmpctl_pkg::CMPCTL_ADDR_CTRL_STATUS,
      cmpctl_pkg::CMPCTL_ADDR_CONV_CTRL_B,
      cmpctl_pkg::CMPCTL_ADDR_INPUT_DIS,
      cmpctl_pkg::CMPCTL_ADDR_CONV_CTRL_A,
      cmpctl_pkg::CMPCTL_ADDR_CONV_MUX,
      cmpctl_pkg::CMPCTL_ADDR_IRQ_STATUS,
      cmpctl_pkg::CMPCTL_ADDR_IRQ_CLEAR,
      cmpctl_pkg::CMPCTL_ADDR_IRQ_ENABLE: hit = 1'b1;
      default:                            hit = 1'b0;
    endcase
  end

  logic wr_ctrl;
  logic wr_b;
  logic wr_dis;
  logic wr_a;
  logic wr_mux;
  logic wr_iclr;
  logic wr_ien;

  assign wr_ctrl = wr & lane0 & (adr_i == cmpctl_pkg::CMPCTL_ADDR_CTRL_STATUS);
  assign wr_b    = wr & lane0 & (adr_i == cmpctl_pkg::CMPCTL_ADDR_CONV_CTRL_B);
  assign wr_dis  = wr & lane0 & (adr_i == cmpctl_pkg::CMPCTL_ADDR_INPUT_DIS);
  assign wr_a    = wr & lane0 & (adr_i == cmpctl_pkg::CMPCTL_ADDR_CONV_CTRL_A);
  assign wr_mux  = wr & lane0 & (adr_i == cmpctl_pkg::CMPCTL_ADDR_CONV_MUX);
  assign wr_iclr = wr & lane0 & (adr_i == cmpctl_pkg::CMPCTL_ADDR_IRQ_CLEAR);
  assign wr_ien  = wr & lane0 & (adr_i == cmpctl_pkg::CMPCTL_ADDR_IRQ_ENABLE);

  // Ack one cycle after the request; unmapped addresses answer with err
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack_r <= 1'b0;
      err_r <= 1'b0;
    end
    else if (ce_i)
    begin
      ack_r <= req & hit;
      err_r <= req & ~hit;
    end
  end

  // Read data captured with the answer
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      rdata_r <= 32'h0000_0000;
    else if (ce_i && req)
    begin
      rdata_r <= 32'h0000_0000;
      case (adr_i)
        cmpctl_pkg::CMPCTL_ADDR_CTRL_STATUS:
          rdata_r[7:0] <= {ctrl_r[7:6], edge_if.out_sync, irq_flag_r,
                           ctrl_r[3:0]};
        cmpctl_pkg::CMPCTL_ADDR_CONV_CTRL_B:
          rdata_r[7:0] <= conv_b_r;
        cmpctl_pkg::CMPCTL_ADDR_INPUT_DIS:
          rdata_r[7:0] <= {6'h00, in_dis_r};
        cmpctl_pkg::CMPCTL_ADDR_CONV_CTRL_A:
          rdata_r[7:0] <= {conv_en_r, 7'h00};
        cmpctl_pkg::CMPCTL_ADDR_CONV_MUX:
          rdata_r[7:0] <= {5'h00, chan_r};
        cmpctl_pkg::CMPCTL_ADDR_IRQ_STATUS:
          rdata_r[1:0] <= ev_status;
        cmpctl_pkg::CMPCTL_ADDR_IRQ_ENABLE:
          rdata_r[1:0] <= ev_enable;
        default:
          rdata_r <= 32'h0000_0000;
      endcase
    end
  end

  assign ack_o = ack_r;
  assign err_o = err_r;
  assign dat_o = rdata_r;

  // -------------------------------------------------------------------
  // Control registers
  // -------------------------------------------------------------------
  // Software may change the disable bit at any time
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      ctrl_r <= cmpctl_pkg::CMPCTL_RST_BYTE;
    else if (wr_ctrl)
      ctrl_r <= {wb0[7:6], 2'b00, wb0[3:0]};
  end

  // Converter-side bits used by the input mux
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      conv_b_r  <= cmpctl_pkg::CMPCTL_RST_BYTE;
      conv_en_r <= 1'b0;
      chan_r    <= 3'h0;
    end
    else
    begin
      if (wr_b)
        conv_b_r <= wb0 & cmpctl_pkg::CMPCTL_MASK_CONV_B;
      if (wr_a)
        conv_en_r <= wb0[cmpctl_pkg::CMPCTL_BIT_CONV_EN];
      if (wr_mux)
        chan_r <= wb0[2:0];
    end
  end

  // Pin buffer disable bits; upper bits are not stored
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      in_dis_r <= 2'h0;
    else if (wr_dis)
      in_dis_r <= wb0[1:0];
  end

  // -------------------------------------------------------------------
  // Comparator flag
  // -------------------------------------------------------------------
  // Event sets win over vector or software clear
  logic flag_clr;
  assign flag_clr = vector_ack_i
                  | (wr_ctrl & wb0[cmpctl_pkg::CMPCTL_BIT_IRQ_FLAG]);

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      irq_flag_r <= 1'b0;
    else if (ce_i)
    begin
      if (edge_if.event_hit)
        irq_flag_r <= 1'b1;
      else if (flag_clr)
        irq_flag_r <= 1'b0;
    end
  end

  assign edge_if.mode = ctrl_r[1:0];

  // Enable must be cleared by software before a mode change
  assign comp_irq_req_o = irq_flag_r & ctrl_r[cmpctl_pkg::CMPCTL_BIT_IRQ_EN]
                        & global_irq_en_i;

  cmpctl_sampler u_sampler
  (
    .clk_i     (clk_i),
    .rst_i     (rst_i),
    .ce_i      (ce_i),
    .cmp_raw_i (cmp_raw_i),
    .edge_if   (edge_if)
  );

  // -------------------------------------------------------------------
  // Analog selection and routing
  // -------------------------------------------------------------------
  assign comp_power_down_o = ctrl_r[cmpctl_pkg::CMPCTL_BIT_DISABLE];
  assign pos_use_bandgap_o = ctrl_r[cmpctl_pkg::CMPCTL_BIT_BANDGAP];
  // Converter on keeps its mux for itself
  assign neg_use_channel_o = conv_b_r[cmpctl_pkg::CMPCTL_BIT_MUX_EN]
                           & ~conv_en_r;
  assign neg_channel_o     = chan_r;
  // Synced output, not raw, so the timer sees a clean level
  assign capture_in_o = ctrl_r[cmpctl_pkg::CMPCTL_BIT_CAPTURE]
                      & edge_if.out_sync;

  // Disabled buffer reads zero
  assign neg_buffer_off_o = in_dis_r[cmpctl_pkg::CMPCTL_BIT_NEG_BUF];
  assign pos_buffer_off_o = in_dis_r[cmpctl_pkg::CMPCTL_BIT_POS_BUF];
  assign neg_pin_state_o  = neg_pin_raw_i & ~neg_buffer_off_o;
  assign pos_pin_state_o  = pos_pin_raw_i & ~pos_buffer_off_o;

  // -------------------------------------------------------------------
  // Block event interrupt
  // -------------------------------------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      cap_prev_r <= 1'b0;
    else if (ce_i)
      cap_prev_r <= capture_in_o;
  end

  assign ev_set[cmpctl_pkg::CMPCTL_EV_EDGE]    = edge_if.event_hit;
  assign ev_set[cmpctl_pkg::CMPCTL_EV_CAPTURE] = capture_in_o & ~cap_prev_r;
  assign ev_clr = wr_iclr ? wb0[1:0] : 2'b00;

  cmpctl_irq #(.N(cmpctl_pkg::CMPCTL_NUM_EVENTS)) u_irq
  (
    .clk_i      (clk_i),
    .rst_i      (rst_i),
    .ce_i       (ce_i),
    .set_i      (ev_set),
    .clr_i      (ev_clr),
    .en_we_i    (wr_ien),
    .en_wdata_i (wb0[1:0]),
    .status_o   (ev_status),
    .enable_o   (ev_enable),
    .irq_o      (irq_o)
  );

  // -------------------------------------------------------------------
  // Checks
  // -------------------------------------------------------------------
  a_flag_set: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && edge_if.event_hit |=> irq_flag_r)
    else $error("flag not set by event");
  a_flag_clear: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && vector_ack_i && !edge_if.event_hit |=> !irq_flag_r)
    else $error("flag not cleared by vector");
  a_req_gate: assert property (@(posedge clk_i) disable iff (rst_i)
    comp_irq_req_o == (irq_flag_r && ctrl_r[3] && global_irq_en_i))
    else $error("request gating wrong");
  a_mux_neg: assert property (@(posedge clk_i) disable iff (rst_i)
    conv_en_r |-> !neg_use_channel_o)
    else $error("channel used while converter on");
  a_pin_zero: assert property (@(posedge clk_i) disable iff (rst_i)
    in_dis_r[1] |-> !neg_pin_state_o)
    else $error("disabled pin reads high");
  a_resv_zero: assert property (@(posedge clk_i) disable iff (rst_i)
    ack_r && $past(adr_i) == cmpctl_pkg::CMPCTL_ADDR_INPUT_DIS
    |-> dat_o[7:2] == 6'h00)
    else $error("reserved bits nonzero");
  a_ctrl_write: assert property (@(posedge clk_i) disable iff (rst_i)
    wr_ctrl |=> comp_power_down_o == $past(wb0[7]))
    else $error("disable bit not written");
  a_capture_off: assert property (@(posedge clk_i) disable iff (rst_i)
    !ctrl_r[2] |-> !capture_in_o)
    else $error("capture routed while off");

  c_flag_rise: cover property (@(posedge clk_i) irq_flag_r && !$past(irq_flag_r));
  c_req: cover property (@(posedge clk_i) comp_irq_req_o);
  c_chan_use: cover property (@(posedge clk_i) neg_use_channel_o);
  c_err: cover property (@(posedge clk_i) err_o);

endmodule

/* cmpctl_pkg.sv */
// Package for the comparator input control block: register map, field
// positions, reset values and edge-mode codes.
// Assumes an 8-bit register view carried on a 32-bit classic Wishbone bus.
package cmpctl_pkg;

  // ---------------------------------------------------------------------
  // Register byte addresses
  // ---------------------------------------------------------------------
  localparam logic [7:0] CMPCTL_ADDR_CTRL_STATUS = 8'h50;
  localparam logic [7:0] CMPCTL_ADDR_CONV_CTRL_B = 8'h7B;
  localparam logic [7:0] CMPCTL_ADDR_INPUT_DIS   = 8'h80;
  localparam logic [7:0] CMPCTL_ADDR_CONV_CTRL_A = 8'h84;
  localparam logic [7:0] CMPCTL_ADDR_CONV_MUX    = 8'h88;
  localparam logic [7:0] CMPCTL_ADDR_IRQ_STATUS  = 8'h90;
  localparam logic [7:0] CMPCTL_ADDR_IRQ_CLEAR   = 8'h94;
  localparam logic [7:0] CMPCTL_ADDR_IRQ_ENABLE  = 8'h98;

  // ---------------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------------
  localparam int CMPCTL_BIT_DISABLE    = 7;
  localparam int CMPCTL_BIT_BANDGAP    = 6;
  localparam int CMPCTL_BIT_OUT_SYNC   = 5;
  localparam int CMPCTL_BIT_IRQ_FLAG   = 4;
  localparam int CMPCTL_BIT_IRQ_EN     = 3;
  localparam int CMPCTL_BIT_CAPTURE    = 2;
  localparam int CMPCTL_BIT_MODE_HI    = 1;
  localparam int CMPCTL_BIT_MODE_LO    = 0;
  localparam int CMPCTL_BIT_MUX_EN     = 6;
  localparam int CMPCTL_BIT_CONV_EN    = 7;
  localparam int CMPCTL_BIT_NEG_BUF    = 1;
  localparam int CMPCTL_BIT_POS_BUF    = 0;

  // ---------------------------------------------------------------------
  // Reset values and masks
  // ---------------------------------------------------------------------
  localparam logic [7:0] CMPCTL_RST_BYTE      = 8'h00;
  localparam logic [7:0] CMPCTL_MASK_CONV_B   = 8'h47;
  localparam logic [7:0] CMPCTL_MASK_INPUT    = 8'h03;
  localparam logic [7:0] CMPCTL_MASK_CHANNEL  = 8'h07;
  localparam int         CMPCTL_NUM_EVENTS    = 2;
  localparam int         CMPCTL_EV_EDGE       = 0;
  localparam int         CMPCTL_EV_CAPTURE    = 1;

  // ---------------------------------------------------------------------
  // Interrupt mode codes
  // ---------------------------------------------------------------------
  localparam logic [1:0] CMPCTL_MODE_TOGGLE   = 2'h0;
  localparam logic [1:0] CMPCTL_MODE_RESERVED = 2'h1;
  localparam logic [1:0] CMPCTL_MODE_FALL     = 2'h2;
  localparam logic [1:0] CMPCTL_MODE_RISE     = 2'h3;

endpackage

/* cmpctl_edge_if.sv */
// Interface between the comparator sampler and the main control logic.
// Assumes one clock shared by both ends.
`timescale 1ns/1ns
interface cmpctl_edge_if;
  logic       out_sync;
  logic [1:0] mode;
  logic       event_hit;

  modport sampler
  (
    output out_sync,
    input  mode,
    output event_hit
  );
  modport ctrl
  (
    input  out_sync,
    output mode,
    input  event_hit
  );
endinterface

/* cmpctl_sampler.sv */
// Synchroniser and edge detector for the raw comparator output.
// Assumes the raw output is asynchronous to clk_i.
`timescale 1ns/1ns
module cmpctl_sampler
(
  // Clock, reset and enable
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        ce_i,
  // Raw comparator output
  input  wire logic        cmp_raw_i,
  // Towards the control logic
  cmpctl_edge_if.sampler   edge_if
);

  logic meta_r;
  logic sync_r;
  logic prev_r;
  logic hit;

  // -------------------------------------------------------------------
  // Two-stage synchroniser
  // -------------------------------------------------------------------
  // First stage feeds only the second stage
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      meta_r <= 1'b0;
      sync_r <= 1'b0;
    end
    else if (ce_i)
    begin
      meta_r <= cmp_raw_i;
      sync_r <= meta_r;
    end
  end

  // Previous synced value for edge detection
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      prev_r <= 1'b0;
    else if (ce_i)
      prev_r <= sync_r;
  end

  // -------------------------------------------------------------------
  // Edge decode per mode
  // -------------------------------------------------------------------
  // Reserved code detects nothing
  always_comb
  begin
    case (edge_if.mode)
      cmpctl_pkg::CMPCTL_MODE_TOGGLE: hit = sync_r ^ prev_r;
      cmpctl_pkg::CMPCTL_MODE_FALL:   hit = prev_r & ~sync_r;
      cmpctl_pkg::CMPCTL_MODE_RISE:   hit = sync_r & ~prev_r;
      default:                        hit = 1'b0;
    endcase
  end

  assign edge_if.out_sync  = sync_r;
  assign edge_if.event_hit = hit & ce_i;

  a_sync_delay: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && $past(ce_i) |-> sync_r == $past(meta_r))
    else $error("synchroniser stage mismatch");
  a_reserved_quiet: assert property (@(posedge clk_i) disable iff (rst_i)
    edge_if.mode == cmpctl_pkg::CMPCTL_MODE_RESERVED |-> !edge_if.event_hit)
    else $error("event in reserved mode");
  a_rise_detect: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && edge_if.mode == cmpctl_pkg::CMPCTL_MODE_RISE && sync_r && !prev_r
    |-> edge_if.event_hit)
    else $error("rising edge missed");

endmodule

/* cmpctl_irq.sv */
// Sticky status, enable and clear for the block's own event interrupt.
// Assumes single-cycle set pulses and a write-one-to-clear strobe.
`timescale 1ns/1ns
module cmpctl_irq
#(
  parameter int N = 2
)
(
  // Clock, reset and enable
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  input  wire logic         ce_i,
  // Events and software access
  input  wire logic [N-1:0] set_i,
  input  wire logic [N-1:0] clr_i,
  input  wire logic         en_we_i,
  input  wire logic [N-1:0] en_wdata_i,
  // Status
  output logic      [N-1:0] status_o,
  output logic      [N-1:0] enable_o,
  output logic              irq_o
);

  // -------------------------------------------------------------------
  // Sticky bits, set wins over clear
  // -------------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < N; g++)
    begin : g_bit
      always_ff @(posedge clk_i)
      begin
        if (rst_i)
          status_o[g] <= 1'b0;
        else if (ce_i)
          status_o[g] <= set_i[g] | (status_o[g] & ~clr_i[g]);
      end
    end
  endgenerate

  // Enable register
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      enable_o <= '0;
    else if (ce_i && en_we_i)
      enable_o <= en_wdata_i;
  end

  assign irq_o = |(status_o & enable_o);

endmodule

/* cmpctl_analog_model.sv */
// Behavioural analog comparator core and timer capture counter.
// Assumes the select outputs of cmpctl_top and 4-bit stand-in voltages.
`timescale 1ns/1ns
module cmpctl_analog_model
#(
  parameter logic [3:0] BG_LEVEL = 4'h8
)
(
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Selects from the block
  input  wire logic        power_down_i,
  input  wire logic        use_bandgap_i,
  input  wire logic        use_channel_i,
  input  wire logic [2:0]  channel_i,
  input  wire logic        capture_in_i,
  // Stand-in voltages, channel k in bits 4k+3:4k
  input  wire logic [3:0]  pos_level_i,
  input  wire logic [3:0]  neg_level_i,
  input  wire logic [31:0] chan_levels_i,
  // Results
  output logic             cmp_raw_o,
  output logic [7:0]       capture_count_o
);
  // ---------------------------------------------------------------
  // Input selection and compare
  // ---------------------------------------------------------------
  logic [3:0] plus_v;
  logic [3:0] minus_v;
  logic       cap_q;

  // Plus input: reference or pin
  assign plus_v  = use_bandgap_i ? BG_LEVEL : pos_level_i;
  // Minus input: converter channel only when the block says so
  assign minus_v = use_channel_i ? chan_levels_i[channel_i*4 +: 4]
                                 : neg_level_i;
  // Unpowered core is taken as low; a real one may float
  assign cmp_raw_o = !power_down_i && (plus_v > minus_v);

  // Counts rising edges seen by the capture front end
  always_ff @(posedge clk_i)
  begin
    cap_q <= capture_in_i;
    if (rst_i)
      capture_count_o <= 8'h00;
    else if (capture_in_i && !cap_q)
      capture_count_o <= capture_count_o + 8'h01;
  end
endmodule

/* tb_cmpctl_top.sv */
// Self-checking bench for cmpctl_top over classic Wishbone.
// Assumes the analog model closes the loop from selects to raw output.
`timescale 1ns/1ns
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin failures++; $display("[ERR] %s exp %0h got %0h", n, e, g); end end
module tb_cmpctl_top;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
  logic [7:0]  adr_i = 8'h00;
  logic [3:0]  sel_i = 4'h0;
  logic [31:0] dat_i = 32'h0;
  logic [31:0] dat_o;
  logic        ack_o, err_o, req_o, irq_o, raw, pd, bg, use_ch, cap;
  logic [2:0]  chan;
  logic        gie = 1'b0, vack = 1'b0, nraw = 1'b1, praw = 1'b1;
  logic        nst, pst, noff, poff;
  logic [3:0]  pos_lv = 4'h0;
  logic [7:0]  cap_cnt, d, c0;
  logic        e;
  int          failures = 0;
  int          checks_done = 0;

  // 250 MHz clock
  always #2 clk_i = ~clk_i;

  cmpctl_top i_cmpctl_top (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1),
    .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i),
    .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .err_o(err_o),
    .global_irq_en_i(gie), .vector_ack_i(vack), .comp_irq_req_o(req_o),
    .irq_o(irq_o), .cmp_raw_i(raw), .comp_power_down_o(pd),
    .pos_use_bandgap_o(bg), .neg_use_channel_o(use_ch),
    .neg_channel_o(chan), .capture_in_o(cap), .neg_pin_raw_i(nraw),
    .pos_pin_raw_i(praw), .neg_pin_state_o(nst), .pos_pin_state_o(pst),
    .neg_buffer_off_o(noff), .pos_buffer_off_o(poff));

  cmpctl_analog_model i_cmpctl_analog_model (.clk_i(clk_i), .rst_i(rst_i),
    .power_down_i(pd), .use_bandgap_i(bg), .use_channel_i(use_ch),
    .channel_i(chan), .capture_in_i(cap), .pos_level_i(pos_lv),
    .neg_level_i(4'h5), .chan_levels_i(32'hECA86420), .cmp_raw_o(raw),
    .capture_count_o(cap_cnt));

  task automatic final_report;
    if (failures == 0 && checks_done > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // One classic cycle; holds everything until ack or err is sampled
  task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] wd);
    int n;
    @(posedge clk_i);
    cyc_i <= 1'b1; stb_i <= 1'b1; we_i <= w; adr_i <= a;
    sel_i <= 4'h1; dat_i <= {24'h0, wd};
    for (n = 0; n < 20; n++)
    begin
      @(posedge clk_i);
      if (ack_o === 1'b1 || err_o === 1'b1)
        break;
    end
    if (n == 20)
    begin
      failures++;
      final_report();
    end
    d = dat_o[7:0];
    e = err_o;
    cyc_i <= 1'b0; stb_i <= 1'b0; we_i <= 1'b0;
  endtask

  task automatic waitc(input int n);
    repeat (n) @(posedge clk_i);
  endtask

  task automatic t_reset;
    wb(0, 8'h50, 8'h00); `CHK("ctrl", 8'h00, d)
    wb(0, 8'h7B, 8'h00); `CHK("conv_b", 8'h00, d)
    wb(0, 8'h80, 8'h00); `CHK("in_dis", 8'h00, d)
    wb(0, 8'h10, 8'h00); `CHK("unmapped err", 1'b1, e)
  endtask

  // Channel select through the converter mux, then converter takes it
  task automatic t_mux;
    pos_lv <= 4'h7;
    wb(1, 8'h7B, 8'hFF); wb(0, 8'h7B, 8'h00); `CHK("conv_b", 8'h47, d)
    for (int k = 0; k < 8; k++)
    begin
      wb(1, 8'h88, k[7:0]); waitc(4);
      `CHK("use_ch", 1'b1, use_ch)
      `CHK("chan", k[2:0], chan)
      wb(0, 8'h50, 8'h00); `CHK("out", (k < 4), d[5])
    end
    wb(1, 8'h84, 8'h80); waitc(4);
    `CHK("use_ch conv on", 1'b0, use_ch)
    wb(0, 8'h50, 8'h00); `CHK("out pin", 1'b1, d[5])
    wb(1, 8'h84, 8'h00); wb(1, 8'h7B, 8'h00);
    `CHK("use_ch mux off", 1'b0, use_ch)
  endtask

  // Every edge mode, enable kept clear while the mode changes
  task automatic t_edges;
    logic [1:0] m;
    logic [1:0] modes [4] = '{2'h0, 2'h2, 2'h3, 2'h1};
    for (int i = 0; i < 4; i++)
    begin
      m = modes[i];
      pos_lv <= 4'h0; waitc(5);
      wb(1, 8'h50, {6'h00, m});
      wb(1, 8'h50, {6'h04, m}); pos_lv <= 4'hF; waitc(5);
      wb(0, 8'h50, 8'h00); `CHK("out", 1'b1, d[5])
      `CHK("rise flag", (m == 2'h0 || m == 2'h3), d[4])
      wb(1, 8'h50, {6'h00, m}); wb(0, 8'h50, 8'h00);
      `CHK("write 0 keeps", (m == 2'h0 || m == 2'h3), d[4])
      wb(1, 8'h50, {6'h04, m}); wb(0, 8'h50, 8'h00);
      `CHK("write 1 clears", 1'b0, d[4])
      pos_lv <= 4'h0; waitc(5); wb(0, 8'h50, 8'h00);
      `CHK("fall flag", (m == 2'h0 || m == 2'h2), d[4])
    end
  endtask

  // Request gating, vector clear, event status and its interrupt line
  task automatic t_irq;
    wb(1, 8'h50, 8'h13); wb(1, 8'h98, 8'h01);
    pos_lv <= 4'hF; waitc(5);
    `CHK("req no en", 1'b0, req_o)
    `CHK("irq_o", 1'b1, irq_o)
    wb(0, 8'h90, 8'h00); `CHK("ev status", 1'b1, d[0])
    wb(1, 8'h50, 8'h0B); `CHK("req no gie", 1'b0, req_o)
    gie <= 1'b1; waitc(2); `CHK("req", 1'b1, req_o)
    wb(1, 8'h94, 8'h01); waitc(1); `CHK("irq_o clr", 1'b0, irq_o)
    vack <= 1'b1; waitc(1); vack <= 1'b0; waitc(2);
    `CHK("req after vec", 1'b0, req_o)
    wb(0, 8'h50, 8'h00); `CHK("flag after vec", 1'b0, d[4])
    wb(1, 8'h50, 8'h03); wb(1, 8'h98, 8'h00); wb(1, 8'h50, 8'h00);
    pos_lv <= 4'h0; waitc(5);
  endtask

  // Power, reference, capture route and pin buffers
  task automatic t_misc;
    pos_lv <= 4'hF;
    wb(1, 8'h50, 8'hC0); waitc(4);
    `CHK("pd", 1'b1, pd)
    `CHK("bg", 1'b1, bg)
    wb(0, 8'h50, 8'h00); `CHK("out pd", 1'b0, d[5])
    pos_lv <= 4'h0; wb(1, 8'h50, 8'h40); waitc(4);
    wb(0, 8'h50, 8'h00); `CHK("out bg", 1'b1, d[5])
    wb(1, 8'h50, 8'h00); waitc(4); wb(1, 8'h50, 8'h04);
    c0 = cap_cnt; pos_lv <= 4'hF; waitc(5);
    `CHK("cap in", 1'b1, cap)
    `CHK("cap count", c0 + 8'h01, cap_cnt)
    wb(0, 8'h90, 8'h00); `CHK("cap status", 1'b1, d[1])
    wb(1, 8'h50, 8'h00); `CHK("cap off", 1'b0, cap)
    `CHK("pst on", 1'b1, pst)
    wb(1, 8'h80, 8'hFF); wb(0, 8'h80, 8'h00); `CHK("in_dis", 8'h03, d)
    `CHK("noff", 1'b1, noff)
    `CHK("nst", 1'b0, nst)
    wb(1, 8'h80, 8'h01);
    `CHK("pst off", 1'b0, pst)
    `CHK("nst on", 1'b1, nst)
  endtask

  // Reset, then the scenarios in turn
  initial
  begin
    waitc(16);
    rst_i <= 1'b0;
    t_reset();
    t_mux();
    t_edges();
    t_irq();
    t_misc();
    final_report();
  end
endmodule
